// File: rtl/cit_core_timing.sv
`timescale 1ns/100ps
// Function
// [RULE_01] Every opcode decodes with the standard eight-bit encoding, addressing mode and flag behaviour.
// [RULE_02] Instruction length is counted in plain clock cycles with no machine cycle.
// [RULE_03] No instruction runs longer than eight clocks.
// [RULE_04] A conditional branch that is not taken ends one clock before the taken case.
// [RULE_05] Most instructions take as many clocks as they have bytes.
// [RULE_06] The core is static from zero to 25 MHz and can retire one instruction per clock.
// [RULE_07] There are 109 instructions, 26 of one clock and 50 of two.
// [RULE_08] Add and add_with_carry take one clock from a working_register and two from other operands.
// [RULE_09] Subtract_with_borrow takes one clock from a register and two otherwise, indirect being one byte.
// [RULE_10] Logic ops of an immediate into a direct byte are three bytes and three clocks.
// [RULE_11] Logic ops with an indirect_ram_operand into the accumulator are one byte and two clocks.
// [RULE_12] Logic ops of the accumulator into a direct byte are two bytes and two clocks.
// [RULE_13] Logic ops with a working_register into the accumulator are one byte and one clock.
// [RULE_14] Jump_if_acc_zero is two bytes, two clocks not taken and three taken.
// [RULE_15] External_data_move takes three clocks for both address widths.
// [RULE_16] Multiply_op takes four clocks and divide_op eight, the only eight-clock instruction.
// [RULE_17] Incrementing the data_pointer is one byte and one clock, all sixteen bits at once.
module cit_core_timing (
    // Clock, reset, enable
    input wire logic MCLK,
    input wire logic RESETN,
    input wire logic CE,
    // Code memory, read combinationally at CODE_ADDR
    output logic [15:0] CODE_ADDR,
    input wire logic [7:0] CODE_DATA,
    // Datapath status and branch target
    input wire cit_pkg::cit_flags_s FLAGS,
    input wire logic [15:0] TARGET_PC,
    // Progress and retirement
    output logic [7:0] CUR_OPCODE,
    output logic [3:0] CUR_CYCLE,
    output logic INSTR_DONE,
    output cit_pkg::cit_retire_s RETIRE
);
    import cit_pkg::*;

    cit_state_e st_ff, nxt_st;
    logic [15:0] pc_ff, nxt_pc;
    logic [7:0] op_ff, nxt_op;
    logic [3:0] cnt_ff, nxt_cnt;
    logic done_ff, nxt_done;
    cit_retire_s ret_ff, nxt_ret;

    logic [7:0] op_sel;
    cit_dec_s dec;
    logic [3:0] cyc_now;
    logic is_cond;
    logic take;
    logic fetch;
    logic short_end;
    logic full_end;

    // Opcode byte is decoded in the very cycle it arrives
    assign op_sel = (st_ff == CIT_ST_OPCODE) ? CODE_DATA : op_ff;

    cit_opdec u_dec (
        .OPCODE(op_sel),
        .DEC(dec)
    );

    // Condition of the current branch, sampled only in its decision cycle
    always_comb begin
        unique case (dec.csel)
            CIT_C_ACC_ZERO: take = FLAGS.acc_zero; // see [RULE_14]
            CIT_C_ACC_NZ: take = !FLAGS.acc_zero;
            CIT_C_CARRY: take = FLAGS.carry;
            CIT_C_NCARRY: take = !FLAGS.carry;
            CIT_C_BIT: take = FLAGS.bit_set;
            CIT_C_NBIT: take = !FLAGS.bit_set;
            CIT_C_CMP_NE: take = FLAGS.cmp_ne;
            CIT_C_DEC_NZ: take = FLAGS.dec_nz;
            CIT_C_NONE: take = 1'b1;
            default: take = 1'b1;
        endcase
    end

    // Cycle sequencing: one code byte per clock, no machine cycle
    always_comb begin
        nxt_st = st_ff;
        nxt_pc = pc_ff;
        nxt_op = op_ff;
        nxt_cnt = cnt_ff;
        nxt_done = 1'b0;
        nxt_ret = ret_ff;
        cyc_now = (st_ff == CIT_ST_OPCODE) ? CIT_CYC_ONE : cnt_ff + CIT_CYC_ONE; // see [RULE_02]
        is_cond = (dec.csel != CIT_C_NONE);
        // Extra clocks past the byte count fetch nothing, so CODE_ADDR waits for the next opcode
        fetch = (cyc_now <= {2'h0, dec.bytes}); // see [RULE_05]
        short_end = is_cond && (cyc_now == dec.cyc - CIT_CYC_ONE) && !take; // see [RULE_04]
        full_end = (cyc_now == dec.cyc) || (cyc_now >= CIT_MAX_CYC); // see [RULE_03]
        if (fetch) begin
            nxt_pc = pc_ff + CIT_PC_STEP;
        end
        if (st_ff == CIT_ST_OPCODE) begin
            nxt_op = CODE_DATA;
        end
        if (short_end || full_end) begin
            // Single-clock opcodes stay in the opcode state: one per clock
            nxt_st = CIT_ST_OPCODE; // see [RULE_06]
            nxt_cnt = CIT_CNT_IDLE;
            nxt_done = 1'b1;
            nxt_ret.opcode = op_sel;
            nxt_ret.bytes = dec.bytes;
            nxt_ret.cycles = cyc_now;
            nxt_ret.taken = is_cond && !short_end;
            nxt_ret.mode = dec.mode;
            if (full_end && dec.redir) begin
                nxt_pc = TARGET_PC;
            end
        end else begin
            nxt_st = CIT_ST_EXEC;
            nxt_cnt = cyc_now;
        end
    end

    // Low CE freezes everything, including a pending done pulse
    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            st_ff <= CIT_ST_OPCODE;
            pc_ff <= CIT_PC_RESET;
            op_ff <= 8'h00;
            cnt_ff <= CIT_CNT_IDLE;
            done_ff <= 1'b0;
            ret_ff <= '0;
        end else if (CE) begin
            st_ff <= nxt_st;
            pc_ff <= nxt_pc;
            op_ff <= nxt_op;
            cnt_ff <= nxt_cnt;
            done_ff <= nxt_done;
            ret_ff <= nxt_ret;
        end
    end

    assign CODE_ADDR = pc_ff;
    assign CUR_OPCODE = op_ff;
    assign CUR_CYCLE = cnt_ff;
    assign INSTR_DONE = done_ff;
    assign RETIRE = ret_ff;

    AST_MAX_EIGHT: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_03]
        INSTR_DONE |-> (RETIRE.cycles >= CIT_CYC_ONE) && (RETIRE.cycles <= CIT_MAX_CYC))
        else $error("instruction ran outside one to eight clocks");

    AST_CYCLE_STEP: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_02]
        (CE && st_ff == CIT_ST_EXEC && !nxt_done) |=> (cnt_ff == $past(cnt_ff) + CIT_CYC_ONE))
        else $error("cycle count did not advance by one");

    AST_NOT_TAKEN_SHORT: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_04]
        (CE && nxt_done && is_cond && !nxt_ret.taken) |-> (nxt_ret.cycles == dec.cyc - CIT_CYC_ONE))
        else $error("untaken branch not one clock short");

    AST_ADD_REG: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_08]
        (INSTR_DONE && RETIRE.opcode >= CIT_OP_ADD_REG_LO && RETIRE.opcode <= CIT_OP_ADD_WITH_CARRY_REG_HI
         && RETIRE.opcode[3]) |-> (RETIRE.cycles == 4'h1) && (RETIRE.bytes == 2'h1))
        else $error("register add not one byte one clock");

    AST_SUBTRACT_WITH_BORROW_IND: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_09]
        (INSTR_DONE && (RETIRE.opcode == CIT_OP_SUBTRACT_WITH_BORROW_IND0 || RETIRE.opcode == CIT_OP_SUBTRACT_WITH_BORROW_IND1))
        |-> (RETIRE.cycles == 4'h2) && (RETIRE.bytes == 2'h1))
        else $error("indirect subtract timing wrong");

    AST_LOGIC_DIR_IMM: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_10]
        (INSTR_DONE && RETIRE.opcode[3:0] == 4'h3 && RETIRE.opcode[7:4] inside {4'h4, 4'h5, 4'h6})
        |-> (RETIRE.cycles == 4'h3) && (RETIRE.bytes == CIT_BYTES_MAX))
        else $error("logic immediate to direct not three and three");

    AST_LOGIC_IND: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_11]
        (INSTR_DONE && RETIRE.opcode[3:1] == 3'h3 && RETIRE.opcode[7:4] inside {4'h4, 4'h5, 4'h6})
        |-> (RETIRE.cycles == 4'h2) && (RETIRE.bytes == 2'h1) && (RETIRE.mode == CIT_MODE_IND))
        else $error("indirect logic op timing wrong");

    AST_LOGIC_DIR_A: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_12]
        (INSTR_DONE && RETIRE.opcode[3:0] == 4'h2 && RETIRE.opcode[7:4] inside {4'h4, 4'h5, 4'h6})
        |-> (RETIRE.cycles == 4'h2) && (RETIRE.bytes == 2'h2))
        else $error("accumulator to direct logic op timing wrong");

    AST_LOGIC_REG: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_13]
        (INSTR_DONE && RETIRE.opcode[3] && RETIRE.opcode[7:4] inside {4'h4, 4'h5, 4'h6})
        |-> (RETIRE.cycles == 4'h1) && (RETIRE.mode == CIT_MODE_REG))
        else $error("register logic op timing wrong");

    // Decision cycle of a zero jump is its second clock; the flag is ignored elsewhere
    AST_JZ_NOT_TAKEN: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_14]
        (CE && st_ff == CIT_ST_EXEC && op_ff == CIT_OP_JZ && cnt_ff == CIT_CYC_ONE && !FLAGS.acc_zero)
        |=> INSTR_DONE && !RETIRE.taken && RETIRE.cycles == 4'h2 && RETIRE.bytes == 2'h2)
        else $error("untaken zero jump not two clocks");

    AST_JZ_WAIT: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_14]
        (CE && st_ff == CIT_ST_EXEC && op_ff == CIT_OP_JZ && cnt_ff == CIT_CYC_ONE && FLAGS.acc_zero)
        |=> !INSTR_DONE && cnt_ff == 4'h2)
        else $error("taken zero jump ended early");

    AST_JZ_TAKEN: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_14]
        (CE && st_ff == CIT_ST_EXEC && op_ff == CIT_OP_JZ && cnt_ff == 4'h2)
        |=> INSTR_DONE && RETIRE.taken && RETIRE.cycles == 4'h3 && CODE_ADDR == $past(TARGET_PC))
        else $error("taken zero jump not three clocks");

    // A frozen clock must not count towards any instruction length
    AST_FREEZE_HOLD: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_02]
        !CE |=> $stable(CODE_ADDR) && $stable(CUR_CYCLE) && $stable(INSTR_DONE) && $stable(RETIRE))
        else $error("state moved while clock enable low");

    AST_EXT_MOVE: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_15]
        (INSTR_DONE && RETIRE.opcode[7:5] == 3'h7 && RETIRE.opcode[3:2] == 2'h0
         && RETIRE.opcode[1:0] != 2'h1) |-> (RETIRE.cycles == 4'h3) && (RETIRE.mode == CIT_MODE_EXT))
        else $error("external move not three clocks");

    AST_MUL_DIV: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_16]
        INSTR_DONE |-> ((RETIRE.cycles == CIT_MAX_CYC) == (RETIRE.opcode == CIT_OP_DIV))
                    && ((RETIRE.opcode != CIT_OP_MUL) || (RETIRE.cycles == 4'h4)))
        else $error("multiply or divide timing wrong");

    AST_INC_PTR: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_17]
        (CE && st_ff == CIT_ST_OPCODE && CODE_DATA == CIT_OP_INC_DATA_POINTER)
        |=> INSTR_DONE && RETIRE.cycles == 4'h1 && CODE_ADDR == $past(CODE_ADDR) + CIT_PC_STEP)
        else $error("pointer increment not single clock");

    AST_BACK_TO_BACK: assert property (@(posedge MCLK) disable iff (!RESETN) // see [RULE_06]
        (CE && st_ff == CIT_ST_OPCODE && dec.cyc == CIT_CYC_ONE) |=> (INSTR_DONE && st_ff == CIT_ST_OPCODE))
        else $error("single clock opcode did not retire next edge");

endmodule : cit_core_timing

// File: rtl/cit_pkg.sv
package cit_pkg;

    // Clocking: core is fully static, so any rate up to the ceiling works
    localparam int CIT_CLK_HZ = 20000000;
    localparam int CIT_MAX_CLK_HZ = 25000000;

    // Cycle and byte figures
    localparam logic [3:0] CIT_CYC_ONE = 4'h1;
    localparam logic [3:0] CIT_MAX_CYC = 4'h8;
    localparam logic [3:0] CIT_CNT_IDLE = 4'h0;
    localparam logic [1:0] CIT_BYTES_MAX = 2'h3;

    // Program counter
    localparam logic [15:0] CIT_PC_RESET = 16'h0000;
    localparam logic [15:0] CIT_PC_STEP = 16'h0001;

    // Opcodes with fixed timing that the checks look at
    localparam logic [7:0] CIT_OP_JZ = 8'h60;
    localparam logic [7:0] CIT_OP_MUL = 8'hA4;
    localparam logic [7:0] CIT_OP_DIV = 8'h84;
    localparam logic [7:0] CIT_OP_INC_DATA_POINTER = 8'hA3;
    localparam logic [7:0] CIT_OP_ADD_REG_LO = 8'h28;
    localparam logic [7:0] CIT_OP_ADD_WITH_CARRY_REG_HI = 8'h3F;
    localparam logic [7:0] CIT_OP_SUBTRACT_WITH_BORROW_IND0 = 8'h96;
    localparam logic [7:0] CIT_OP_SUBTRACT_WITH_BORROW_IND1 = 8'h97;

    // Operand addressing modes
    typedef enum logic [2:0] {
        CIT_MODE_IMPL,
        CIT_MODE_REG,
        CIT_MODE_IND,
        CIT_MODE_DIR,
        CIT_MODE_IMM,
        CIT_MODE_EXT,
        CIT_MODE_REL
    } cit_mode_e;

    // Branch condition selects
    typedef enum logic [3:0] {
        CIT_C_NONE,
        CIT_C_ACC_ZERO,
        CIT_C_ACC_NZ,
        CIT_C_CARRY,
        CIT_C_NCARRY,
        CIT_C_BIT,
        CIT_C_NBIT,
        CIT_C_CMP_NE,
        CIT_C_DEC_NZ
    } cit_cond_e;

    typedef enum logic {
        CIT_ST_OPCODE,
        CIT_ST_EXEC
    } cit_state_e;

    // Decoded timing of one opcode; cyc is the taken (full) duration
    typedef struct packed {
        logic [1:0] bytes;
        logic [3:0] cyc;
        logic redir;
        cit_cond_e csel;
        cit_mode_e mode;
    } cit_dec_s;

    // Status from the datapath, valid in the branch decision cycle
    typedef struct packed {
        logic acc_zero;
        logic carry;
        logic bit_set;
        logic cmp_ne;
        logic dec_nz;
    } cit_flags_s;

    // Summary of a retired instruction
    typedef struct packed {
        logic [7:0] opcode;
        logic [1:0] bytes;
        logic [3:0] cycles;
        logic taken;
        cit_mode_e mode;
    } cit_retire_s;

endpackage : cit_pkg

// File: rtl/cit_opdec.sv
`timescale 1ns/100ps
module cit_opdec (
    // Opcode in
    input wire logic [7:0] OPCODE,
    // Timing out
    output cit_pkg::cit_dec_s DEC
);
    import cit_pkg::*;

    function automatic cit_dec_s mk(input logic [1:0] b, input logic [3:0] c, input cit_mode_e m,
                                    input cit_cond_e cs, input logic rd);
        cit_dec_s r;
        r.bytes = b;
        r.cyc = c;
        r.mode = m;
        r.csel = cs;
        r.redir = rd;
        return r;
    endfunction : mk

    logic [3:0] hi;
    assign hi = OPCODE[7:4];

    // Standard opcode map, grouped by low nibble (see [RULE_01]) (see [RULE_07])
    always_comb begin
        DEC = mk(2'h1, 4'h1, CIT_MODE_IMPL, CIT_C_NONE, 1'b0);
        unique case (OPCODE[3:0])
            4'h0: begin
                case (hi)
                    4'h0: DEC = mk(2'h1, 4'h1, CIT_MODE_IMPL, CIT_C_NONE, 1'b0);
                    4'h1, 4'h2: DEC = mk(2'h3, 4'h4, CIT_MODE_REL, CIT_C_BIT, 1'b1);
                    4'h3: DEC = mk(2'h3, 4'h4, CIT_MODE_REL, CIT_C_NBIT, 1'b1);
                    4'h4: DEC = mk(2'h2, 4'h3, CIT_MODE_REL, CIT_C_CARRY, 1'b1);
                    4'h5: DEC = mk(2'h2, 4'h3, CIT_MODE_REL, CIT_C_NCARRY, 1'b1);
                    4'h6: DEC = mk(2'h2, 4'h3, CIT_MODE_REL, CIT_C_ACC_ZERO, 1'b1); // see [RULE_14]
                    4'h7: DEC = mk(2'h2, 4'h3, CIT_MODE_REL, CIT_C_ACC_NZ, 1'b1);
                    4'h8: DEC = mk(2'h2, 4'h3, CIT_MODE_REL, CIT_C_NONE, 1'b1);
                    4'h9: DEC = mk(2'h3, 4'h3, CIT_MODE_IMM, CIT_C_NONE, 1'b0);
                    4'hE, 4'hF: DEC = mk(2'h1, 4'h3, CIT_MODE_EXT, CIT_C_NONE, 1'b0); // see [RULE_15]
                    default: DEC = mk(2'h2, 4'h2, CIT_MODE_DIR, CIT_C_NONE, 1'b0);
                endcase
            end
            4'h1: DEC = mk(2'h2, 4'h3, CIT_MODE_IMPL, CIT_C_NONE, 1'b1);
            4'h2: begin
                case (hi)
                    4'h0, 4'h1: DEC = mk(2'h3, 4'h4, CIT_MODE_IMPL, CIT_C_NONE, 1'b1);
                    4'h2, 4'h3: DEC = mk(2'h1, 4'h5, CIT_MODE_IMPL, CIT_C_NONE, 1'b1);
                    4'hE, 4'hF: DEC = mk(2'h1, 4'h3, CIT_MODE_EXT, CIT_C_NONE, 1'b0); // see [RULE_15]
                    default: DEC = mk(2'h2, 4'h2, CIT_MODE_DIR, CIT_C_NONE, 1'b0); // see [RULE_12]
                endcase
            end
            4'h3: begin
                case (hi)
                    4'h4, 4'h5, 4'h6: DEC = mk(2'h3, 4'h3, CIT_MODE_DIR, CIT_C_NONE, 1'b0); // see [RULE_10]
                    4'h7: DEC = mk(2'h1, 4'h3, CIT_MODE_IMPL, CIT_C_NONE, 1'b1);
                    4'h8, 4'h9: DEC = mk(2'h1, 4'h3, CIT_MODE_IMPL, CIT_C_NONE, 1'b0);
                    4'hE, 4'hF: DEC = mk(2'h1, 4'h3, CIT_MODE_EXT, CIT_C_NONE, 1'b0); // see [RULE_15]
                    default: DEC = mk(2'h1, 4'h1, CIT_MODE_IMPL, CIT_C_NONE, 1'b0); // see [RULE_17]
                endcase
            end
            4'h4: begin
                case (hi)
                    4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: DEC = mk(2'h1, 4'h1, CIT_MODE_IMPL, CIT_C_NONE, 1'b0);
                    4'h8: DEC = mk(2'h1, 4'h8, CIT_MODE_IMPL, CIT_C_NONE, 1'b0); // see [RULE_16]
                    4'hA: DEC = mk(2'h1, 4'h4, CIT_MODE_IMPL, CIT_C_NONE, 1'b0); // see [RULE_16]
                    4'hB: DEC = mk(2'h3, 4'h4, CIT_MODE_IMM, CIT_C_CMP_NE, 1'b1);
                    default: DEC = mk(2'h2, 4'h2, CIT_MODE_IMM, CIT_C_NONE, 1'b0); // see [RULE_08]
                endcase
            end
            4'h5: begin
                case (hi)
                    4'h7, 4'h8: DEC = mk(2'h3, 4'h3, CIT_MODE_DIR, CIT_C_NONE, 1'b0);
                    4'hA: DEC = mk(2'h1, 4'h1, CIT_MODE_IMPL, CIT_C_NONE, 1'b0);
                    4'hB: DEC = mk(2'h3, 4'h4, CIT_MODE_DIR, CIT_C_CMP_NE, 1'b1);
                    4'hD: DEC = mk(2'h3, 4'h4, CIT_MODE_DIR, CIT_C_DEC_NZ, 1'b1);
                    default: DEC = mk(2'h2, 4'h2, CIT_MODE_DIR, CIT_C_NONE, 1'b0); // see [RULE_05]
                endcase
            end
            4'h6, 4'h7: begin
                case (hi)
                    4'h7, 4'h8, 4'hA: DEC = mk(2'h2, 4'h2, CIT_MODE_IND, CIT_C_NONE, 1'b0);
                    4'hB: DEC = mk(2'h3, 4'h5, CIT_MODE_IND, CIT_C_CMP_NE, 1'b1);
                    default: DEC = mk(2'h1, 4'h2, CIT_MODE_IND, CIT_C_NONE, 1'b0); // see [RULE_09] (see [RULE_11])
                endcase
            end
            default: begin
                case (hi)
                    4'h7, 4'h8, 4'hA: DEC = mk(2'h2, 4'h2, CIT_MODE_REG, CIT_C_NONE, 1'b0);
                    4'hB: DEC = mk(2'h3, 4'h4, CIT_MODE_REG, CIT_C_CMP_NE, 1'b1);
                    4'hD: DEC = mk(2'h2, 4'h3, CIT_MODE_REG, CIT_C_DEC_NZ, 1'b1);
                    default: DEC = mk(2'h1, 4'h1, CIT_MODE_REG, CIT_C_NONE, 1'b0); // see [RULE_13]
                endcase
            end
        endcase
    end

endmodule : cit_opdec

// File: tb/cit_code_mem.sv
`timescale 1ns/100ps
module cit_code_mem (
    // Fetch port
    input wire logic [15:0] ADDR,
    output logic [7:0] DATA
);
    logic [7:0] mem [0:255];

    // Read in the same cycle as the address; upper address bits alias, so programs stay small
    assign DATA = mem[ADDR[7:0]];

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'h00;
        end
    end
endmodule : cit_code_mem

// File: tb/cit_core_timing_test.sv
`timescale 1ns/100ps
module cit_core_timing_test;
    import cit_pkg::*;

    typedef struct packed {
        logic [7:0] op;
        logic [1:0] b;
        logic [3:0] c;
        logic t;
        logic mc;
        cit_mode_e m;
    } cit_case_s;

    localparam int NCASE = 39;
    localparam logic [15:0] TGT = 16'h0040;
    // Mode is compared only where the operand form is unambiguous
    cit_case_s cases [NCASE] = '{
        '{8'h28, 2'h1, 4'h1, 1'h0, 1'h1, CIT_MODE_REG}, '{8'h25, 2'h2, 4'h2, 1'h0, 1'h1, CIT_MODE_DIR},
        '{8'h26, 2'h1, 4'h2, 1'h0, 1'h1, CIT_MODE_IND}, '{8'h24, 2'h2, 4'h2, 1'h0, 1'h1, CIT_MODE_IMM},
        '{8'h3F, 2'h1, 4'h1, 1'h0, 1'h1, CIT_MODE_REG}, '{8'h35, 2'h2, 4'h2, 1'h0, 1'h1, CIT_MODE_DIR},
        '{8'h37, 2'h1, 4'h2, 1'h0, 1'h1, CIT_MODE_IND}, '{8'h34, 2'h2, 4'h2, 1'h0, 1'h1, CIT_MODE_IMM},
        '{8'h98, 2'h1, 4'h1, 1'h0, 1'h1, CIT_MODE_REG}, '{8'h95, 2'h2, 4'h2, 1'h0, 1'h1, CIT_MODE_DIR},
        '{8'h97, 2'h1, 4'h2, 1'h0, 1'h1, CIT_MODE_IND}, '{8'h94, 2'h2, 4'h2, 1'h0, 1'h1, CIT_MODE_IMM},
        '{8'h53, 2'h3, 4'h3, 1'h0, 1'h0, CIT_MODE_IMPL}, '{8'h43, 2'h3, 4'h3, 1'h0, 1'h0, CIT_MODE_IMPL},
        '{8'h63, 2'h3, 4'h3, 1'h0, 1'h0, CIT_MODE_IMPL}, '{8'h56, 2'h1, 4'h2, 1'h0, 1'h1, CIT_MODE_IND},
        '{8'h46, 2'h1, 4'h2, 1'h0, 1'h1, CIT_MODE_IND}, '{8'h66, 2'h1, 4'h2, 1'h0, 1'h1, CIT_MODE_IND},
        '{8'h52, 2'h2, 4'h2, 1'h0, 1'h0, CIT_MODE_IMPL}, '{8'h42, 2'h2, 4'h2, 1'h0, 1'h0, CIT_MODE_IMPL},
        '{8'h62, 2'h2, 4'h2, 1'h0, 1'h0, CIT_MODE_IMPL}, '{8'h58, 2'h1, 4'h1, 1'h0, 1'h1, CIT_MODE_REG},
        '{8'h48, 2'h1, 4'h1, 1'h0, 1'h1, CIT_MODE_REG}, '{8'h68, 2'h1, 4'h1, 1'h0, 1'h1, CIT_MODE_REG},
        '{8'h60, 2'h2, 4'h3, 1'h1, 1'h0, CIT_MODE_IMPL}, '{8'h60, 2'h2, 4'h2, 1'h0, 1'h0, CIT_MODE_IMPL},
        '{8'hE0, 2'h1, 4'h3, 1'h0, 1'h0, CIT_MODE_IMPL}, '{8'hF0, 2'h1, 4'h3, 1'h0, 1'h0, CIT_MODE_IMPL},
        '{8'hE2, 2'h1, 4'h3, 1'h0, 1'h0, CIT_MODE_IMPL}, '{8'hF2, 2'h1, 4'h3, 1'h0, 1'h0, CIT_MODE_IMPL},
        '{8'hA4, 2'h1, 4'h4, 1'h0, 1'h0, CIT_MODE_IMPL}, '{8'h84, 2'h1, 4'h8, 1'h0, 1'h0, CIT_MODE_IMPL},
        '{8'hA3, 2'h1, 4'h1, 1'h0, 1'h0, CIT_MODE_IMPL}, '{8'hA5, 2'h1, 4'h1, 1'h0, 1'h0, CIT_MODE_IMPL},
        '{8'h40, 2'h2, 4'h3, 1'h1, 1'h0, CIT_MODE_IMPL}, '{8'h20, 2'h3, 4'h4, 1'h1, 1'h0, CIT_MODE_IMPL},
        '{8'hB4, 2'h3, 4'h4, 1'h1, 1'h0, CIT_MODE_IMPL}, '{8'hB6, 2'h3, 4'h4, 1'h0, 1'h0, CIT_MODE_IMPL},
        '{8'hD8, 2'h2, 4'h3, 1'h1, 1'h0, CIT_MODE_IMPL}
    };

    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    cit_flags_s flags = '0;
    logic [15:0] target_pc = TGT;
    logic [15:0] code_addr;
    logic [7:0] code_data;
    logic [7:0] cur_opcode;
    logic [3:0] cur_cycle;
    logic instr_done;
    cit_retire_s retire;
    int error_cnt = 0;
    int cmp_count = 0;

    always #25 mclk = ~mclk;

    cit_core_timing i_dut (
        .MCLK(mclk), .RESETN(resetn), .CE(ce), .CODE_ADDR(code_addr), .CODE_DATA(code_data),
        .FLAGS(flags), .TARGET_PC(target_pc), .CUR_OPCODE(cur_opcode), .CUR_CYCLE(cur_cycle),
        .INSTR_DONE(instr_done), .RETIRE(retire)
    );

    cit_code_mem i_mem (.ADDR(code_addr), .DATA(code_data));

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic finish_test();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    // Program starts at address zero on the first edge after this returns
    task automatic do_reset(input logic zero);
        @(posedge mclk);
        resetn <= 1'b0;
        // Every condition source follows the taken bit, so positive-sense branches all take
        flags <= cit_flags_s'({5{zero}});
        repeat (2) @(posedge mclk);
        resetn <= 1'b1;
    endtask : do_reset

    task automatic run_case(input cit_case_s cc);
        int n;
        n = 0;
        i_mem.mem[0] = cc.op;
        do_reset(cc.t);
        while (n < 20 && instr_done !== 1'b1) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("clocks_to_done", 16'(cc.c), 16'(n));
        chk("retire_cycles", 16'(cc.c), 16'(retire.cycles));
        chk("retire_bytes", 16'(cc.b), 16'(retire.bytes));
        chk("retire_opcode", 16'(cc.op), 16'(retire.opcode));
        chk("retire_taken", 16'(cc.t), 16'(retire.taken));
        chk("code_addr", cc.t ? TGT : 16'(cc.b), code_addr);
        if (cc.mc) begin
            chk("retire_mode", 16'(cc.m), 16'(retire.mode));
        end
    endtask : run_case

    // Single-clock ops retire on consecutive edges, then a two-clock op leaves one gap
    task automatic t_back_to_back();
        logic [7:0] prog [5];
        prog = '{8'h28, 8'h58, 8'hA3, 8'hA5, 8'h25};
        for (int i = 0; i < 5; i++) begin
            i_mem.mem[i] = prog[i];
        end
        do_reset(1'b0);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            #1;
            chk("b2b_done", 16'h0001, 16'(instr_done));
            chk("b2b_opcode", 16'(prog[i]), 16'(retire.opcode));
        end
        @(posedge mclk);
        #1;
        chk("b2b_gap", 16'h0000, 16'(instr_done));
        @(posedge mclk);
        #1;
        chk("b2b_last", 16'h0025, instr_done ? 16'(retire.opcode) : 16'hFFFF);
    endtask : t_back_to_back

    // Divide frozen mid-run still needs eight enabled clocks in all
    task automatic t_freeze();
        int n;
        n = 0;
        i_mem.mem[0] = 8'h84;
        do_reset(1'b0);
        repeat (3) @(posedge mclk);
        ce <= 1'b0;
        #1;
        chk("run_cycle", 16'h0003, 16'(cur_cycle));
        repeat (4) @(posedge mclk);
        ce <= 1'b1;
        #1;
        chk("frozen_cycle", 16'h0003, 16'(cur_cycle));
        chk("frozen_addr", 16'h0001, code_addr);
        chk("frozen_opcode", 16'(CIT_OP_DIV), 16'(cur_opcode));
        while (n < 20 && instr_done !== 1'b1) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("frozen_rest", 16'h0005, 16'(n));
    endtask : t_freeze

    initial begin
        repeat (20) @(posedge mclk);
        for (int i = 0; i < NCASE; i++) begin
            run_case(cases[i]);
        end
        t_back_to_back();
        t_freeze();
        finish_test();
    end

    // Whole run is some 250 clocks; this is ample margin
    initial begin
        #400000;
        error_cnt++;
        finish_test();
    end
endmodule : cit_core_timing_test
